/* File: logic/pin_select_pkg.sv */
// package: register map, field layout and sizes of the pin select mapper
package pin_select_pkg;

  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int NUM_PHYS_PINS     = 56;
  localparam int VIRTUAL_PIN_FIRST = 176;
  localparam int VIRTUAL_PIN_LAST  = 181;
  localparam int NUM_VIRTUAL_PINS  = VIRTUAL_PIN_LAST - VIRTUAL_PIN_FIRST + 1;
  localparam int NUM_PERIPH_INPUTS = 8;
  localparam int NUM_PERIPH_OUTPUTS = 16;
  localparam int NUM_OUT_PINS      = 4;
  localparam int FIRST_OUT_PIN     = 52;
  localparam int IN_SEL_W          = 8;
  localparam int OUT_FUNC_W        = 6;
  localparam int WORD_BYTES          = 4;
  localparam int IN_FIELDS_PER_WORD  = 4;
  localparam int OUT_FIELDS_PER_WORD = 2;
  localparam int NUM_VIRT_WORDS      = NUM_VIRTUAL_PINS / OUT_FIELDS_PER_WORD;

  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [11:0] IN_SEL_BASE_OFS  = 12'h000;
  localparam logic [11:0] OUT_ASSIGN_52_53_OFS = 12'h040;
  localparam logic [11:0] OUT_ASSIGN_54_55_OFS = 12'h044;
  localparam logic [11:0] VIRT_ASSIGN_BASE_OFS = 12'h048;
  localparam logic [11:0] PIN_STATE_OFS    = 12'h080;
  localparam logic [11:0] VIRT_STATE_OFS   = 12'h084;

  // ----------------------------------------
  // field layout and reset values
  // ----------------------------------------
  localparam int LO_FIELD_LSB = 0;
  localparam int HI_FIELD_LSB = 8;
  localparam int STATUS_PAD_LSB = 16;
  localparam logic [IN_SEL_W-1:0]   IN_SEL_RESET   = 8'h00;
  localparam logic [OUT_FUNC_W-1:0] OUT_FUNC_RESET = 6'h00;
  localparam logic [OUT_FUNC_W-1:0] OUT_FUNC_NONE  = 6'h00;

  // ----------------------------------------
  // bus carriers
  // ----------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_s;

endpackage

/* File: logic/peripheral_pin_select_mapper.sv */
// top: remappable pin select mapper with virtual pins and an APB register file
// ----------------------------------------
// Functional notes
// - each peripheral input owns one select field
// - input select fields are eight bits wide
// - select value n routes pin n
// - six virtual pins numbered 176 to 181
// - virtual pins never touch package pins
// - virtual pin output feeds selecting inputs
// - pins 52/53 function selects in register
// - pins 54/55 function selects in register
// - bits 15:14 and 7:6 read zero
// ----------------------------------------
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module peripheral_pin_select_mapper #(
  parameter int NumInputs  = pin_select_pkg::NUM_PERIPH_INPUTS,
  parameter int NumOutputs = pin_select_pkg::NUM_PERIPH_OUTPUTS
) (
  input  wire logic                                        ref_clk,
  input  wire logic                                        rstn,
  input  wire pin_select_pkg::apb_req_s                    apbReq,
  output      pin_select_pkg::apb_rsp_s                    apbRsp,
  input  wire logic [pin_select_pkg::NUM_PHYS_PINS-1:0]    padIn,
  input  wire logic [NumOutputs-1:0]                       periphOut,
  output      logic [NumInputs-1:0]                        periphIn,
  output      logic [pin_select_pkg::NUM_OUT_PINS-1:0]     padOut,
  output      logic [pin_select_pkg::NUM_OUT_PINS-1:0]     padOe
);
  import pin_select_pkg::*;

  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [IN_SEL_W-1:0]   inSel_reg   [NumInputs];
  localparam int NumInWords = (NumInputs + IN_FIELDS_PER_WORD - 1) / IN_FIELDS_PER_WORD;
  logic [OUT_FUNC_W-1:0] outFunc_reg [NUM_OUT_PINS];
  logic [OUT_FUNC_W-1:0] virtFunc_reg [NUM_VIRTUAL_PINS];
  logic [NUM_VIRTUAL_PINS-1:0] virtPin_reg;
  logic [NUM_OUT_PINS-1:0]     outPinLevel;
  logic [NUM_OUT_PINS-1:0]     outPinUsed;
  logic [NUM_VIRTUAL_PINS-1:0] virtLevel;
  logic [NumInputs-1:0]        routedIn;
  logic [31:0]                 readData;
  logic                        readOk;
  logic                        access;
  logic                        wrEn;
  logic                        setupPhase;
  logic                        ready_reg;
  logic                        slvErr_reg;
  logic [31:0]                 rdata_reg;
  logic [NumInWords-1:0]       inWordHit;
  logic [NUM_VIRT_WORDS-1:0]   virtWordHit;
  logic                        out5253Hit;
  logic                        out5455Hit;
  logic                        statusHit;
  logic                        virtStateHit;

  // bus phases: setup is the first cycle of a transfer, access the second
  assign access     = apbReq.psel && apbReq.penable;
  assign wrEn       = access && apbReq.pwrite;
  assign setupPhase = apbReq.psel && !apbReq.penable;

  // ----------------------------------------
  // address decode, shared by writes, reads and the error answer
  // ----------------------------------------
  // one hit line per input select word
  genvar gw;
  generate
    for (gw = 0; gw < NumInWords; gw++) begin : g_inHit
      assign inWordHit[gw] = (apbReq.paddr == IN_SEL_BASE_OFS + 12'(WORD_BYTES * gw));
    end
  endgenerate

  // one hit line per virtual pin assignment word
  generate
    for (gw = 0; gw < NUM_VIRT_WORDS; gw++) begin : g_virtHit
      assign virtWordHit[gw] = (apbReq.paddr == VIRT_ASSIGN_BASE_OFS + 12'(WORD_BYTES * gw));
    end
  endgenerate

  // fixed registers
  assign out5253Hit   = (apbReq.paddr == OUT_ASSIGN_52_53_OFS);
  assign out5455Hit   = (apbReq.paddr == OUT_ASSIGN_54_55_OFS);
  assign statusHit    = (apbReq.paddr == PIN_STATE_OFS);
  assign virtStateHit = (apbReq.paddr == VIRT_STATE_OFS);

  // any mapped word; every other address answers with an error
  assign readOk = (|inWordHit) || (|virtWordHit) || out5253Hit || out5455Hit || statusHit || virtStateHit;

  // ----------------------------------------
  // output function select per physical output pin
  // ----------------------------------------
  // code 0 leaves the pin unassigned, code k picks peripheral output k-1
  function automatic logic funcLevel(input logic [OUT_FUNC_W-1:0] code, input logic [NumOutputs-1:0] outs);
    logic lvl;
    lvl = 1'b0;
    for (int k = 1; k <= NumOutputs; k++) begin
      if (int'(code) == k) begin
        lvl = outs[k-1];
      end
    end
    return lvl;
  endfunction

  genvar gp;
  generate
    for (gp = 0; gp < NUM_OUT_PINS; gp++) begin : g_outPin
      assign outPinLevel[gp] = funcLevel(outFunc_reg[gp], periphOut);
      assign outPinUsed[gp]  = (outFunc_reg[gp] != OUT_FUNC_NONE);
    end
  endgenerate

  // ----------------------------------------
  // virtual pins: internal only, fed from software-chosen peripheral outputs
  // ----------------------------------------
  // field position of the k-th pin inside a two-field assignment word
  function automatic int fieldLsb(input int k);
    return (k % OUT_FIELDS_PER_WORD == 0) ? LO_FIELD_LSB : HI_FIELD_LSB;
  endfunction

  // same function codes as the physical pins; no pad is read or driven here
  generate
    for (gp = 0; gp < NUM_VIRTUAL_PINS; gp++) begin : g_virt
      assign virtLevel[gp] = funcLevel(virtFunc_reg[gp], periphOut);
    end
  endgenerate

  // registered copy so virtual levels are visible for readback
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      virtPin_reg <= '0;
    end else begin
      virtPin_reg <= virtLevel;
    end
  end

  // ----------------------------------------
  // input routing: one select field per peripheral input
  // ----------------------------------------
  generate
    for (gp = 0; gp < NumInputs; gp++) begin : g_inRoute
      always_comb begin
        int n;
        n = int'(inSel_reg[gp]);
        if (n < NUM_PHYS_PINS) begin
          routedIn[gp] = padIn[n];
        end else if (n >= VIRTUAL_PIN_FIRST && n <= VIRTUAL_PIN_LAST) begin
          routedIn[gp] = virtLevel[n - VIRTUAL_PIN_FIRST];
        end else begin
          routedIn[gp] = 1'b0; // unimplemented pin number
        end
      end
    end
  endgenerate

  // routed peripheral inputs leave from flip-flops
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      periphIn <= '0;
    end else begin
      periphIn <= routedIn;
    end
  end

  // pad levels leave from flip-flops
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      padOut <= '0;
    end else begin
      padOut <= outPinLevel;
    end
  end

  // pad drive enables: high only while a function is assigned
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      padOe <= '0;
    end else begin
      padOe <= outPinUsed;
    end
  end

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  // input select words hold four 8-bit fields each
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NumInputs; i++) begin
        inSel_reg[i] <= IN_SEL_RESET;
      end
    end else if (wrEn) begin
      for (int i = 0; i < NumInputs; i++) begin
        if (inWordHit[i / IN_FIELDS_PER_WORD]) begin
          inSel_reg[i] <= apbReq.pwdata[(i % IN_FIELDS_PER_WORD) * IN_SEL_W +: IN_SEL_W];
        end
      end
    end
  end

  // output assignment: high field odd pin, low field even pin
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_OUT_PINS; i++) begin
        outFunc_reg[i] <= OUT_FUNC_RESET;
      end
    end else if (wrEn) begin
      if (out5253Hit) begin
        outFunc_reg[0] <= apbReq.pwdata[LO_FIELD_LSB +: OUT_FUNC_W];
        outFunc_reg[1] <= apbReq.pwdata[HI_FIELD_LSB +: OUT_FUNC_W];
      end
      if (out5455Hit) begin
        outFunc_reg[2] <= apbReq.pwdata[LO_FIELD_LSB +: OUT_FUNC_W];
        outFunc_reg[3] <= apbReq.pwdata[HI_FIELD_LSB +: OUT_FUNC_W];
      end
    end
  end

  // virtual pin assignment: same layout, even pin low field, odd pin high field
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int v = 0; v < NUM_VIRTUAL_PINS; v++) begin
        virtFunc_reg[v] <= OUT_FUNC_RESET;
      end
    end else if (wrEn) begin
      for (int v = 0; v < NUM_VIRTUAL_PINS; v++) begin
        if (virtWordHit[v / OUT_FIELDS_PER_WORD]) begin
          virtFunc_reg[v] <= apbReq.pwdata[fieldLsb(v) +: OUT_FUNC_W];
        end
      end
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  // unmapped words and spare bits read as zero
  always_comb begin
    readData = 32'h0000_0000;
    for (int i = 0; i < NumInputs; i++) begin
      if (inWordHit[i / IN_FIELDS_PER_WORD]) begin
        readData[(i % IN_FIELDS_PER_WORD) * IN_SEL_W +: IN_SEL_W] = inSel_reg[i];
      end
    end
    if (out5253Hit) begin
      readData[LO_FIELD_LSB +: OUT_FUNC_W] = outFunc_reg[0];
      readData[HI_FIELD_LSB +: OUT_FUNC_W] = outFunc_reg[1];
    end
    if (out5455Hit) begin
      readData[LO_FIELD_LSB +: OUT_FUNC_W] = outFunc_reg[2];
      readData[HI_FIELD_LSB +: OUT_FUNC_W] = outFunc_reg[3];
    end
    for (int v = 0; v < NUM_VIRTUAL_PINS; v++) begin
      if (virtWordHit[v / OUT_FIELDS_PER_WORD]) begin
        readData[fieldLsb(v) +: OUT_FUNC_W] = virtFunc_reg[v];
      end
    end
    if (statusHit) begin
      readData[NumInputs-1:0] = periphIn;
      readData[STATUS_PAD_LSB +: NUM_OUT_PINS] = padOut;
    end
    if (virtStateHit) begin
      readData[NUM_VIRTUAL_PINS-1:0] = virtPin_reg;
    end
  end

  // ----------------------------------------
  // APB answer: no wait state, error on unmapped address
  // ----------------------------------------
  // ready rises for the access cycle that follows every setup cycle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= setupPhase;
    end
  end

  // error flags an unmapped address, together with ready
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      slvErr_reg <= 1'b0;
    end else begin
      slvErr_reg <= setupPhase && !readOk;
    end
  end

  // read data latched at setup; writes and unmapped words answer zero
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= (setupPhase && !apbReq.pwrite) ? readData : 32'h0000_0000;
    end
  end

  // response carrier straight from the three registers ready_reg, slvErr_reg and rdata_reg
  assign apbRsp = '{pready: ready_reg, pslverr: slvErr_reg, prdata: rdata_reg};

endmodule

/* File: testbench/pin_select_properties.sv */
// checker: bus timing and register layout properties of the pin select mapper
`timescale 1ns/1ps
module pin_select_properties (
  input wire logic                     ref_clk,
  input wire logic                     rstn,
  input wire pin_select_pkg::apb_req_s apbReq,
  input wire pin_select_pkg::apb_rsp_s apbRsp
);
  import pin_select_pkg::*;
  logic outReg;
  logic mapped;
  // ----------------------------------------
  // address decode
  // ----------------------------------------
  assign outReg = apbReq.paddr inside {OUT_ASSIGN_52_53_OFS, OUT_ASSIGN_54_55_OFS,
    VIRT_ASSIGN_BASE_OFS, 12'h04C, 12'h050};
  assign mapped = outReg || apbReq.paddr inside {IN_SEL_BASE_OFS, 12'h004, PIN_STATE_OFS, VIRT_STATE_OFS};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence setup_s;
    apbReq.psel && !apbReq.penable;
  endsequence
  sequence access_s;
    apbReq.psel && apbReq.penable && apbRsp.pready;
  endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_ready_after_setup: assert property (setup_s |=> access_s)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (apbRsp.pready |=> !apbRsp.pready)
    else $error("ready held too long");
  a_idle_no_ready: assert property (!apbReq.psel |=> !apbRsp.pready)
    else $error("ready without request");
  a_err_with_ready: assert property (apbRsp.pslverr |-> apbRsp.pready)
    else $error("error without ready");
  a_err_read_zero: assert property (apbRsp.pslverr && !apbReq.pwrite |-> apbRsp.prdata == '0)
    else $error("refused read data not zero");
  a_out_spare_zero: assert property (access_s ##0 (outReg && !apbReq.pwrite)
    |-> apbRsp.prdata[31:14] == '0 && apbRsp.prdata[7:6] == 2'h0)
    else $error("spare output bits not zero");
  a_mapped_no_err: assert property (access_s ##0 mapped |-> !apbRsp.pslverr)
    else $error("mapped access refused");
  a_unmapped_err: assert property (access_s ##0 !mapped |-> apbRsp.pslverr)
    else $error("unmapped access accepted");
endmodule

/* File: testbench/periph_pin_model.sv */
// partner: peripherals and package pins feeding the mapper
`timescale 1ns/1ps
module periph_pin_model (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic [55:0] padSet,
  input  wire logic [15:0] outSet,
  output      logic [55:0] padIn,
  output      logic [15:0] periphOut
);
  // pin levels and peripheral outputs change only on a clock edge
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      padIn     <= '0;
      periphOut <= '0;
    end else begin
      padIn     <= padSet;
      periphOut <= outSet;
    end
  end
endmodule

/* File: testbench/tb_top.sv */
// testbench: register access and routing scenarios for the pin select mapper
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb_top;
  import pin_select_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  apb_req_s    apbReq = '0;
  apb_rsp_s    apbRsp;
  logic [55:0] padSet = '0;
  logic [55:0] padIn;
  logic [15:0] outSet = '0;
  logic [15:0] periphOut;
  logic [7:0]  periphIn;
  logic [3:0]  padOut;
  logic [3:0]  padOe;
  logic [31:0] rdat;
  int          mismatches = 0;
  int          n_compared = 0;
  always #25 ref_clk = ~ref_clk;
  periph_pin_model u_model (.ref_clk(ref_clk), .rstn(rstn), .padSet(padSet), .outSet(outSet),
    .padIn(padIn), .periphOut(periphOut));
  peripheral_pin_select_mapper u_dut (.ref_clk(ref_clk), .rstn(rstn), .apbReq(apbReq), .apbRsp(apbRsp),
    .padIn(padIn), .periphOut(periphOut), .periphIn(periphIn), .padOut(padOut), .padOe(padOe));
  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one apb transfer, held until ready, then an idle cycle
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic xe);
    int k;
    k = 0;
    apbReq <= '{1'b1, 1'b0, w, a, d};
    @(posedge ref_clk);
    apbReq.penable <= 1'b1;
    do begin @(posedge ref_clk); k++; end while (apbRsp.pready !== 1'b1 && k < 16);
    if (k == 16) begin mismatches++; print_verdict; end
    rdat = apbRsp.prdata;
    `CHK("pslverr", xe, apbRsp.pslverr)
    apbReq <= '0;
    @(posedge ref_clk);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x, input string n);
    apb(1'b0, a, 32'h0, 1'b0);
    `CHK(n, x, rdat)
  endtask
  task settle;
    repeat (4) @(posedge ref_clk);
  endtask
  task t_reset;
    rd(IN_SEL_BASE_OFS, 32'h0, "insel0");
    rd(12'h004, 32'h0, "insel1");
    rd(OUT_ASSIGN_52_53_OFS, 32'h0, "out5253");
    rd(VIRT_ASSIGN_BASE_OFS, 32'h0, "virtAssign");
    `CHK("padOe", 4'h0, padOe)
  endtask
  task t_outreg;
    apb(1'b1, OUT_ASSIGN_52_53_OFS, 32'hFFFFFFFF, 1'b0);
    rd(OUT_ASSIGN_52_53_OFS, 32'h00003F3F, "out5253");
    apb(1'b1, OUT_ASSIGN_54_55_OFS, 32'h0000C1C2, 1'b0);
    rd(OUT_ASSIGN_54_55_OFS, 32'h00000102, "out5455");
  endtask
  task t_unmapped;
    apb(1'b1, 12'h0C0, 32'hFFFFFFFF, 1'b1);
    apb(1'b0, 12'h0C0, 32'h0, 1'b1);
    `CHK("unmapped", 32'h0, rdat)
  endtask
  task t_inroute;
    apb(1'b1, 12'h000, 32'h03020100, 1'b0);
    apb(1'b1, 12'h004, 32'h07060504, 1'b0);
    padSet <= 56'hA5;
    settle;
    `CHK("periphIn", 8'hA5, periphIn)
    for (int n = 9; n < 56; n += 46) begin
      apb(1'b1, 12'h000, {4{n[7:0]}}, 1'b0);
      apb(1'b1, 12'h004, {4{n[7:0]}}, 1'b0);
      padSet <= 56'h1 << n;
      settle;
      `CHK("periphIn", 8'hFF, periphIn)
    end
  endtask
  task t_virtual;
    apb(1'b1, 12'h000, 32'hB3B2B1B0, 1'b0);
    apb(1'b1, 12'h004, 32'h0000B5B4, 1'b0);
    apb(1'b1, VIRT_ASSIGN_BASE_OFS, 32'h0102, 1'b0);
    apb(1'b1, 12'h04C, 32'hFFFFC3C4, 1'b0);
    apb(1'b1, 12'h050, 32'h0506, 1'b0);
    rd(12'h04C, 32'h00000304, "virtAssign");
    padSet <= '1;
    outSet <= 16'h0015;
    settle;
    `CHK("periphIn", 8'hEA, periphIn)
    rd(VIRT_STATE_OFS, 32'h2A, "virt");
  endtask
  task t_outfunc;
    apb(1'b1, OUT_ASSIGN_52_53_OFS, 32'h0201, 1'b0);
    apb(1'b1, OUT_ASSIGN_54_55_OFS, 32'h0010, 1'b0);
    outSet <= 16'h8001;
    settle;
    `CHK("padOut", 4'h5, padOut)
    `CHK("padOe", 4'h7, padOe)
    outSet <= 16'h0002;
    settle;
    `CHK("padOut", 4'h2, padOut)
    rd(PIN_STATE_OFS, 32'h000200C1, "status");
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    t_reset;
    t_outreg;
    t_unmapped;
    t_inroute;
    t_virtual;
    t_outfunc;
    print_verdict;
  end
endmodule
bind peripheral_pin_select_mapper pin_select_properties u_props (.ref_clk(ref_clk), .rstn(rstn),
  .apbReq(apbReq), .apbRsp(apbRsp));
